// file: hw/vtp_ctrl.sv
// Vector table placement controller: control register on a Wishbone slave,
// protected vector select change, reset and vector address generation and
// interrupt blocking. Assumes fuse and CPU inputs are synchronous to mclk.
//
// Functional notes
// [R1] Vectors come from flash start when the select bit is 0, else from the boot section start.
// [R2] The boot section start follows the boot size fuses, word 3800h for a 4 Kbyte section.
// [R3] Reset address is the boot section start when the reset fuse is programmed, else 000h.
// [R4] The vector table starts two words above its base, so vectors run from base+2 to base+28h.
// [R5] Software sets the change enable bit, then within four cycles writes select with enable 0.
// [R6] The select bit changes only through that protected sequence.
// [R7] Hardware clears the change enable four cycles after it is set or when select is written.
// [R8] Interrupts are masked from the enable set until the instruction after the select write ends.
// [R9] Without a select write, the mask lifts after four cycles.
// [R10] The automatic mask never alters the global interrupt enable flag.
// [R11] Boot-placed vectors with the application guard programmed block interrupts in app code.
// [R12] App-placed vectors with the boot guard programmed block interrupts in boot code.
// [R13] Control register: irq1, irq0, irq2 enables at 7..5, select at 1, change enable at 0, reset 0.
// [R14] A fuse value of 1 is unprogrammed and 0 is programmed.
// [R15] With select set, each vector address is its application address plus the boot start.
// [R16] Bits 4 to 2 ignore writes and read as zero.
`default_nettype none

module vtp_ctrl
  import vtp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [vtp_pkg::VTP_WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [vtp_pkg::VTP_WB_DW-1:0] wb_dat_i,
  output logic [vtp_pkg::VTP_WB_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Fuses and lock bits, zero means programmed
  input wire logic boot_reset_fuse,
  input wire logic [1:0] boot_size_fuses,
  input wire logic boot_lock_app_guard,
  input wire logic boot_lock_boot_guard,
  // CPU side
  input wire logic global_irq_enable,
  input wire logic exec_in_boot,
  input wire logic instr_done,
  input wire logic [vtp_pkg::VTP_IDX_W-1:0] irq_index,
  output logic [vtp_pkg::VTP_ADDR_W-1:0] reset_addr,
  output logic [vtp_pkg::VTP_ADDR_W-1:0] vector_addr,
  output logic irq_block,
  output logic irq_permit,
  output logic ext_irq1_enable,
  output logic ext_irq0_enable,
  output logic ext_irq2_enable,
  output logic vector_select,
  output logic vector_change_enable
);
  import vtp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  logic wr_acc;
  logic rd_hit;
  logic [7:0] wr_byte;
  logic wr_set;
  logic wr_sel;
  logic [VTP_ADDR_W-1:0] boot_start;
  logic [VTP_ADDR_W-1:0] table_base;
  vtp_state_e state;
  vtp_state_e next_state;
  logic [1:0] cnt;
  logic [1:0] next_cnt;

  // A write counts only at the acking edge, on the mapped word, with lane 0 on
  assign rd_hit = (wb_adr_i == VTP_GIC_OFFSET);
  assign wr_acc = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & rd_hit & wb_sel_i[0];
  assign wr_byte = wb_dat_i[7:0];
  assign wr_set = wr_acc & wr_byte[VTP_BIT_CE];
  // Select write: change enable written 0 while the window is open
  assign wr_sel = wr_acc & ~wr_byte[VTP_BIT_CE] & (state == VTP_WINDOW); // R5

  ////////////////////////////////////////////////////////////////////////////
  // Change sequence state

  // Window timer restarts on every set; the hold waits for the next retire
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      VTP_IDLE: begin
        if (wr_set) begin
          next_state = VTP_WINDOW; // R8
          next_cnt = VTP_CHG_LOAD;
        end
      end
      VTP_WINDOW: begin
        if (wr_set) begin
          next_cnt = VTP_CHG_LOAD;
        end else if (wr_sel) begin
          next_state = VTP_HOLD; // R7
        end else if (cnt == VTP_CNT_ZERO) begin
          next_state = VTP_IDLE; // R7 R9
        end else begin
          next_cnt = cnt - 2'h1;
        end
      end
      VTP_HOLD: begin
        // The write's own instruction retires by its ack edge, so this is the next one
        if (wr_set) begin
          next_state = VTP_WINDOW;
          next_cnt = VTP_CHG_LOAD;
        end else if (instr_done) begin
          next_state = VTP_IDLE; // R8
        end
      end
      default: begin
        next_state = VTP_IDLE;
        next_cnt = VTP_CNT_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= VTP_IDLE;
      cnt <= VTP_CNT_ZERO;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register

  logic [2:0] ext_en;
  logic [2:0] next_ext_en;
  logic next_vsel;

  // Enables store on any write; select only inside the window
  always_comb begin
    next_ext_en = ext_en;
    next_vsel = vector_select;
    if (wr_acc) begin
      next_ext_en = {wr_byte[VTP_BIT_IRQ1], wr_byte[VTP_BIT_IRQ0], wr_byte[VTP_BIT_IRQ2]}; // R13
    end
    if (wr_sel) begin
      next_vsel = wr_byte[VTP_BIT_SEL]; // R6
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ext_en <= VTP_GIC_RESET[VTP_BIT_IRQ1:VTP_BIT_IRQ2];
      vector_select <= VTP_GIC_RESET[VTP_BIT_SEL];
    end else begin
      ext_en <= next_ext_en;
      vector_select <= next_vsel;
    end
  end

  assign ext_irq1_enable = ext_en[2];
  assign ext_irq0_enable = ext_en[1];
  assign ext_irq2_enable = ext_en[0];
  // Change enable reads back as set only while the window is open
  assign vector_change_enable = (state == VTP_WINDOW); // R7

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone answer

  logic next_ack;
  logic [VTP_WB_DW-1:0] next_dat;

  // One wait state; unmapped reads answer zero, unmapped writes are dropped
  always_comb begin
    next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    next_dat = '0;
    if (next_ack && !wb_we_i && rd_hit) begin
      next_dat[7:0] = {ext_en, VTP_RO_VALUE, vector_select, vector_change_enable}; // R13 R16
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address generation

  logic [VTP_ADDR_W-1:0] next_reset_addr;
  logic [VTP_ADDR_W-1:0] next_vector_addr;

  // Boot section start from the size fuses
  always_comb begin
    unique case (boot_size_fuses)
      VTP_BSZ_4K: boot_start = VTP_START_4K; // R2
      VTP_BSZ_2K: boot_start = VTP_START_2K;
      VTP_BSZ_1K: boot_start = VTP_START_1K;
      VTP_BSZ_512: boot_start = VTP_START_512;
    endcase
  end

  assign table_base = vector_select ? boot_start : VTP_APP_START; // R1 R15

  // Fuses are sampled every cycle, so the reset address settles one edge after release
  always_comb begin
    next_reset_addr = (boot_reset_fuse == VTP_FUSE_PROG) ? boot_start : VTP_APP_START; // R3 R14
    next_vector_addr = table_base + VTP_ADDR_W'({irq_index, 1'b0}); // R4 R15
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reset_addr <= VTP_APP_START;
      vector_addr <= VTP_APP_START;
    end else begin
      reset_addr <= next_reset_addr;
      vector_addr <= next_vector_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt blocking

  logic chg_mask;
  logic app_block;
  logic boot_block;

  // The mask sits beside the global enable and never writes it back
  assign chg_mask = (state != VTP_IDLE); // R8 R9
  assign app_block = vector_select & (boot_lock_app_guard == VTP_FUSE_PROG) & ~exec_in_boot; // R11
  assign boot_block = ~vector_select & (boot_lock_boot_guard == VTP_FUSE_PROG) & exec_in_boot; // R12
  assign irq_block = chg_mask | app_block | boot_block;
  assign irq_permit = global_irq_enable & ~irq_block; // R10

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  window_timeout_a: assert property ( // R7
    wr_set ##1 (!wr_acc)[*4] |=> !vector_change_enable)
    else $error("change enable not cleared after four cycles");
  window_open_a: assert property ( // R9
    wr_set ##1 (!wr_acc)[*3] |-> vector_change_enable && irq_block)
    else $error("change window closed early");
  mask_start_a: assert property ( // R8
    wr_set |=> irq_block && !irq_permit)
    else $error("interrupts not masked after enable set");
  sel_guard_a: assert property ( // R6
    $changed(vector_select) |-> $past(wr_acc) && $past(state == VTP_WINDOW))
    else $error("select changed outside window");
  sel_clears_ce_a: assert property ( // R7
    wr_sel && !wr_byte[VTP_BIT_CE] |=> !vector_change_enable && irq_block)
    else $error("select write did not close window");
  hold_mask_a: assert property ( // R8
    state == VTP_HOLD && !instr_done && !wr_set |=> irq_block)
    else $error("mask dropped before next instruction");
  global_ie_a: assert property ( // R10
    !irq_block |-> irq_permit == global_irq_enable)
    else $error("permit does not follow global enable");
  app_guard_a: assert property ( // R11
    vector_select && !boot_lock_app_guard && !exec_in_boot |-> !irq_permit)
    else $error("app guard not blocking");
  boot_guard_a: assert property ( // R12
    !vector_select && !boot_lock_boot_guard && exec_in_boot |-> !irq_permit)
    else $error("boot guard not blocking");
  // Address checks skip the release edge, where the registers still hold reset values
  vec_addr_a: assert property ( // R15
    !rst |=> vector_addr == $past(table_base) + VTP_ADDR_W'({$past(irq_index), 1'b0}))
    else $error("vector address wrong");
  reset_addr_a: assert property ( // R3
    !rst |=> reset_addr == ($past(boot_reset_fuse) ? VTP_APP_START : $past(boot_start)))
    else $error("reset address wrong");
  ro_bits_a: assert property ( // R16
    wb_ack_o && !wb_we_i |-> wb_dat_o[4:2] == VTP_RO_VALUE)
    else $error("read-only bits not zero");
  // Plain writes outside the window must leave the placement alone
  sel_hold_a: assert property ( // R6
    wr_acc && state != VTP_WINDOW |=> $stable(vector_select))
    else $error("select moved by unprotected write");
  ext_store_a: assert property ( // R13
    wr_acc |=> {ext_irq1_enable, ext_irq0_enable, ext_irq2_enable}
      == $past(wr_byte[VTP_BIT_IRQ1:VTP_BIT_IRQ2]))
    else $error("enable bits not stored");
  hold_release_a: assert property ( // R8
    state == VTP_HOLD && instr_done && !wr_set |=> irq_block == (app_block || boot_block))
    else $error("mask kept after next instruction");

  move_boot_c: cover property (wr_set ##[2:4] (wr_sel && wr_byte[VTP_BIT_SEL]));
  window_lapse_c: cover property (wr_set ##1 (!wr_acc)[*5]);
  app_block_c: cover property (app_block && global_irq_enable);
  hold_release_c: cover property (state == VTP_HOLD && instr_done);
  boot_block_c: cover property (boot_block && global_irq_enable);

endmodule : vtp_ctrl

`default_nettype wire

// file: hw/vtp_pkg.sv
// Constants and types for the vector table placement controller.
// Assumes a 100 MHz system clock and word addressed program flash of 16K words.
`default_nettype none

package vtp_pkg;

  // Widths
  localparam int unsigned VTP_WB_AW = 8;
  localparam int unsigned VTP_WB_DW = 32;
  localparam int unsigned VTP_ADDR_W = 14;
  localparam int unsigned VTP_IDX_W = 5;

  // Register map, byte addresses
  localparam logic [VTP_WB_AW-1:0] VTP_GIC_OFFSET = 8'h00;

  // Control register field positions
  localparam int unsigned VTP_BIT_IRQ1 = 7;
  localparam int unsigned VTP_BIT_IRQ0 = 6;
  localparam int unsigned VTP_BIT_IRQ2 = 5;
  localparam int unsigned VTP_BIT_SEL = 1;
  localparam int unsigned VTP_BIT_CE = 0;
  localparam logic [7:0] VTP_GIC_RESET = 8'h00;
  localparam logic [2:0] VTP_RO_VALUE = 3'h0;

  // Change window length in cycles after the enable bit is set
  localparam int unsigned VTP_CHG_CYCLES = 4;
  localparam logic [1:0] VTP_CHG_LOAD = 2'(VTP_CHG_CYCLES - 1);
  localparam logic [1:0] VTP_CNT_ZERO = 2'h0;

  // Fuse polarity: zero means programmed
  localparam logic VTP_FUSE_PROG = 1'b0;

  // Boot section start word addresses, indexed by the boot size fuses
  localparam logic [1:0] VTP_BSZ_4K = 2'h0;
  localparam logic [1:0] VTP_BSZ_2K = 2'h1;
  localparam logic [1:0] VTP_BSZ_1K = 2'h2;
  localparam logic [1:0] VTP_BSZ_512 = 2'h3;
  localparam logic [VTP_ADDR_W-1:0] VTP_START_4K = 14'h3800;
  localparam logic [VTP_ADDR_W-1:0] VTP_START_2K = 14'h3c00;
  localparam logic [VTP_ADDR_W-1:0] VTP_START_1K = 14'h3e00;
  localparam logic [VTP_ADDR_W-1:0] VTP_START_512 = 14'h3f00;
  localparam logic [VTP_ADDR_W-1:0] VTP_APP_START = 14'h0000;

  // Change sequence states, Gray coded along idle, window, hold
  typedef enum logic [1:0] {
    VTP_IDLE = 2'b00,
    VTP_WINDOW = 2'b01,
    VTP_HOLD = 2'b11
  } vtp_state_e;

endpackage : vtp_pkg

`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for vtp_ctrl: register bus, change sequence, addresses, guards.
// Assumes the package, the controller and the CPU model are compiled before it.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vtp_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, slow = 1'b0, exec_in_boot = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic boot_reset_fuse = 1'b1, boot_lock_app_guard = 1'b1, boot_lock_boot_guard = 1'b1;
  logic [1:0] boot_size_fuses = 2'h0;
  logic [4:0] irq_index = 5'h1;
  logic [13:0] reset_addr, vector_addr;
  logic wb_ack_o, irq_block, irq_permit, ext_irq1_enable, ext_irq0_enable, ext_irq2_enable;
  logic vector_select, vector_change_enable, instr_done, global_irq_enable;
  logic [13:0] starts [4] = '{VTP_START_4K, VTP_START_2K, VTP_START_1K, VTP_START_512};
  logic [7:0] rq [$];
  int n_fail = 0, checks = 0, cnt, vcnt;
  integer seed = 32'h4aaa;

  always #5 mclk = ~mclk;

  vtp_cpu_model cpu_u (.mclk, .rst, .slow, .instr_done, .global_irq_enable);
  vtp_ctrl dut_u (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .boot_reset_fuse, .boot_size_fuses, .boot_lock_app_guard,
    .boot_lock_boot_guard, .global_irq_enable, .exec_in_boot, .instr_done, .irq_index,
    .reset_addr, .vector_addr, .irq_block, .irq_permit, .ext_irq1_enable, .ext_irq0_enable,
    .ext_irq2_enable, .vector_select, .vector_change_enable);

  ////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic cmp_sig(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Classic single cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [7:0] e, input logic [3:0] s);
    int n;
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= {24'h0, d};
    if (!w) rq.push_back(e);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Read answers are matched against the oldest note
  always @(posedge mclk) begin
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i) begin
      if (rq.size() == 0) cmp_sig(wb_dat_o, 32'hx, "unexpected read");
      else cmp_sig(wb_dat_o, {24'h0, rq.pop_front()}, "read");
    end
  end

  // Protected select change, then mask held until the next retire
  task automatic sel_seq(input logic [7:0] d);
    int n;
    wb(1'b1, 8'h00, 8'h01, 8'h00, 4'h1);
    wb(1'b1, 8'h00, d, 8'h00, 4'h1);
    @(negedge mclk);
    cmp_sig({vector_select, vector_change_enable, irq_block}, {d[1], 2'b01}, "seq");
    for (n = 0; n < 20; n++) begin
      @(posedge mclk);
      if (instr_done === 1'b1) break;
      @(negedge mclk);
      cmp_sig(irq_block, 1'b1, "held");
    end
    if (n == 20) begin
      n_fail++;
      report_and_stop();
    end
    @(negedge mclk);
    cmp_sig(irq_block, 1'b0, "released");
  endtask

  // Every boot size, both reset fuse values, first, last and random vectors
  task automatic sweep(input logic vs);
    logic [4:0] ix;
    logic [13:0] base;
    for (int s = 0; s < 8; s++) begin
      base = starts[s % 4];
      // First and last vector land on the 4K section at s 4 and 0
      ix = s[0] ? 5'(1 + $unsigned($random(seed)) % 20) : 5'd20;
      if (s == 4) ix = 5'd1;
      @(posedge mclk);
      boot_size_fuses <= 2'(s);
      boot_reset_fuse <= s[2];
      irq_index <= ix;
      @(posedge mclk);
      @(negedge mclk);
      cmp_sig(vector_addr, (vs ? base : 14'h0) + 14'(2 * ix), "vector");
      cmp_sig(reset_addr, s[2] ? 14'h0 : base, "reset");
    end
  endtask

  task automatic guard(input logic a, input logic b, input logic ib, input logic e);
    @(posedge mclk);
    boot_lock_app_guard <= a;
    boot_lock_boot_guard <= b;
    exec_in_boot <= ib;
    @(negedge mclk);
    cmp_sig(irq_block, e, "guard");
    cmp_sig(irq_permit, global_irq_enable & ~e, "permit");
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    wb(1'b0, 8'h00, 8'h00, 8'h00, 4'h1);
    wb(1'b1, 8'h00, 8'hfe, 8'h00, 4'hf);
    wb(1'b0, 8'h00, 8'h00, 8'he0, 4'h1);
    cmp_sig({ext_irq1_enable, ext_irq0_enable, ext_irq2_enable, vector_select}, 4'he, "ext");
    wb(1'b1, 8'h00, 8'h00, 8'h00, 4'he);
    wb(1'b1, 8'h40, 8'h00, 8'h00, 4'h1);
    wb(1'b0, 8'h40, 8'h00, 8'h00, 4'h1);
    wb(1'b0, 8'h00, 8'h00, 8'he0, 4'h1);
    wb(1'b1, 8'h00, 8'h01, 8'h00, 4'h1);
    cnt = 0;
    vcnt = 0;
    repeat (8) begin
      @(negedge mclk);
      cnt += irq_block;
      vcnt += vector_change_enable;
    end
    cmp_sig(cnt, 4, "mask cycles");
    cmp_sig(vcnt, 4, "window cycles");
    wb(1'b1, 8'h00, 8'h02, 8'h00, 4'h1);
    wb(1'b0, 8'h00, 8'h00, 8'h00, 4'h1);
    slow <= 1'b1;
    sel_seq(8'h02);
    wb(1'b0, 8'h00, 8'h00, 8'h02, 4'h1);
    sweep(1'b1);
    guard(1'b0, 1'b1, 1'b0, 1'b1);
    guard(1'b0, 1'b1, 1'b1, 1'b0);
    guard(1'b1, 1'b0, 1'b1, 1'b0);
    // Guards off again, else the boot guard would hide the mask release
    guard(1'b1, 1'b1, 1'b0, 1'b0);
    slow <= 1'b0;
    sel_seq(8'h00);
    sweep(1'b0);
    guard(1'b1, 1'b0, 1'b1, 1'b1);
    guard(1'b1, 1'b0, 1'b0, 1'b0);
    guard(1'b0, 1'b1, 1'b0, 1'b0);
    report_and_stop();
  end
endmodule // testbench

`default_nettype wire

// file: verif/vtp_cpu_model.sv
// CPU model: retires instructions and drives the status interrupt flag.
// Assumes mclk and an active high reset; slow stretches each instruction.
`default_nettype none

module vtp_cpu_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic slow,
  output logic instr_done,
  output logic global_irq_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] phase;

  // One retire pulse a cycle when prompt, one per eight when slow;
  // the flag toggles on its own so the block is seen never to touch it
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase <= 3'h0;
      instr_done <= 1'b0;
      global_irq_enable <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      instr_done <= !slow || phase == 3'h7;
      global_irq_enable <= phase[1];
    end
  end
endmodule // vtp_cpu_model

`default_nettype wire
